/* phy_irq_pkg.sv */
// Constants shared by the management interrupt logic and its serial port.
// Assumes a 10 MHz system clock and a management clock sampled by it.
package phy_irq_pkg;

	typedef logic [4:0] addr_t;
	typedef logic [15:0] word_t;

	// ****************************************************************
	// Register addresses
	// ****************************************************************
	localparam addr_t REG_BASIC_STATUS = 5'h01;
	localparam addr_t REG_LP_ABILITY = 5'h05;
	localparam addr_t REG_AN_EXPANSION = 5'h06;
	localparam addr_t REG_MODE_CTRL = 5'h11;
	localparam addr_t REG_IRQ_FLAGS = 5'h1D;
	localparam addr_t REG_IRQ_MASK = 5'h1E;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_ANC = 5;
	localparam int BIT_RFAULT = 4;
	localparam int BIT_LINK = 2;
	localparam int BIT_ACK = 14;
	localparam int BIT_PDF = 4;
	localparam int BIT_PAGE = 1;
	localparam int BIT_ENERGY = 1;
	localparam int BIT_ALT_SEL = 6;
	localparam int FLAG_ENERGY = 7;
	localparam int FLAG_LINK = 4;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:1] FLAGS_RST = 7'h40;
	localparam logic [7:1] MASK_RST = 7'h00;
	localparam logic [7:1] SRC_PREV_RST = 7'h48;
	localparam logic [7:1] FALL_REL_MASK = 7'h77;
	localparam addr_t PHY_ADDR_DEF = 5'h00;

	// ****************************************************************
	// Serial frame
	// ****************************************************************
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0C;
	localparam logic [4:0] TAIL_LAST = 5'h11;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;

	typedef enum logic [2:0] {
		S_PRE = 3'h1,
		S_HDR = 3'h2,
		S_TAIL = 3'h4
	} smi_state_t;

	typedef enum logic [3:0] {
		E_IDLE = 4'h1,
		E_ARMED = 4'h2,
		E_WAIT = 4'h4,
		E_PULSE = 4'h8
	} late_state_t;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int LATE_DELAY_MS = 1000;
	localparam int LATE_PULSE_MS = 256;
	localparam int LATE_DELAY_CYC_DEF = CLK_HZ / 1000 * LATE_DELAY_MS;
	localparam int LATE_PULSE_CYC_DEF = CLK_HZ / 1000 * LATE_PULSE_MS;

endpackage

/* smi_frame_port.sv */
// Serial management frame engine: decodes read and write frames.
// Assumes mdc and mdio_in come from pins, outside the clk domain.
`timescale 1ns/100ps
module smi_frame_port (
	input wire logic clk,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire phy_irq_pkg::addr_t phy_addr,
	output phy_irq_pkg::addr_t reg_addr,
	input wire phy_irq_pkg::word_t rd_data,
	output phy_irq_pkg::word_t wr_data,
	output logic wr_stb,
	output logic rd_done
);
	import phy_irq_pkg::*;

	// ****************************************************************
	// Pin synchronisers and edge detect
	// ****************************************************************
	logic mdc_s1_r, mdc_s2_r, mdc_s3_r, dio_s1_r, dio_s2_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mdc_s1_r <= 1'b0;
			mdc_s2_r <= 1'b0;
			mdc_s3_r <= 1'b0;
			dio_s1_r <= 1'b1;
			dio_s2_r <= 1'b1;
		end else begin
			mdc_s1_r <= mdc;
			mdc_s2_r <= mdc_s1_r;
			mdc_s3_r <= mdc_s2_r;
			dio_s1_r <= mdio_in;
			dio_s2_r <= dio_s1_r;
		end
	end

	wire logic edge_w = mdc_s2_r & ~mdc_s3_r;
	wire logic bit_w = dio_s2_r;

	// ****************************************************************
	// Frame state
	// ****************************************************************
	smi_state_t st_r;
	logic [5:0] ones_r;
	logic [4:0] cnt_r;
	logic [11:0] hdr_r;
	logic [15:0] in_r, sh_r;
	logic hit_r, rd_r;
	wire logic [12:0] hdr_w = {hdr_r, bit_w};
	wire logic hdr_ok = hdr_w[12] && hdr_w[9:5] == phy_addr;
	wire logic is_rd = hdr_w[11:10] == OP_READ;
	wire logic is_wr = hdr_w[11:10] == OP_WRITE;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= S_PRE;
			ones_r <= 6'h00;
			cnt_r <= 5'h00;
			hdr_r <= 12'h000;
			in_r <= 16'h0000;
			sh_r <= 16'h0000;
			hit_r <= 1'b0;
			rd_r <= 1'b0;
			reg_addr <= 5'h00;
			wr_data <= 16'h0000;
			mdio_out <= 1'b1;
			mdio_oe <= 1'b0;
			wr_stb <= 1'b0;
			rd_done <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_done <= 1'b0;
			if (edge_w) begin
				case (st_r)
				S_PRE: begin
					if (bit_w) begin
						ones_r <= (ones_r == PREAMBLE_LEN) ? ones_r : ones_r + 6'h01;
					end else begin
						ones_r <= 6'h00;
						cnt_r <= 5'h00;
						if (ones_r == PREAMBLE_LEN) begin
							st_r <= S_HDR;
						end
					end
				end
				S_HDR: begin
					hdr_r <= hdr_w[11:0];
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == HDR_LAST) begin
						st_r <= S_TAIL;
						cnt_r <= 5'h00;
						reg_addr <= hdr_w[4:0];
						hit_r <= hdr_ok && (is_rd || is_wr);
						rd_r <= is_rd;
					end
				end
				S_TAIL: begin
					in_r <= {in_r[14:0], bit_w};
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == 5'h00) begin
						sh_r <= rd_data;
						mdio_out <= 1'b0;
						mdio_oe <= hit_r && rd_r;
					end else if (cnt_r == TAIL_LAST) begin
						st_r <= S_PRE;
						ones_r <= 6'h00;
						mdio_out <= 1'b1;
						mdio_oe <= 1'b0;
						wr_data <= {in_r[14:0], bit_w};
						wr_stb <= hit_r && !rd_r;
						rd_done <= hit_r && rd_r;
					end else begin
						mdio_out <= sh_r[15];
						sh_r <= {sh_r[14:0], 1'b0};
					end
				end
				default: begin
					st_r <= S_PRE;
				end
				endcase
			end
		end
	end

endmodule

/* phy_mgmt_interrupt_logic.sv */
// Management interrupt logic: source flags, masks, two release modes.
// Assumes status inputs come from logic on clk; mdc/mdio from pins.
`timescale 1ns/100ps

module phy_mgmt_interrupt_logic #(
	parameter int unsigned LATE_DELAY_CYC = phy_irq_pkg::LATE_DELAY_CYC_DEF,
	parameter int unsigned LATE_PULSE_CYC = phy_irq_pkg::LATE_PULSE_CYC_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire phy_irq_pkg::addr_t phy_addr,
	input wire logic line_energy_present,
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic link_status,
	input wire logic lp_acknowledge,
	input wire logic parallel_det_fault,
	input wire logic page_received,
	input wire logic an_restart,
	output logic irq_out_low,
	output logic alternate_irq_mode_select
);
	import phy_irq_pkg::*;

	function automatic logic reg_is(input addr_t a, input addr_t n);
		reg_is = (a == n);
	endfunction

	// ****************************************************************
	// Serial management port
	// ****************************************************************
	addr_t reg_addr;
	word_t rd_data, wr_data;
	logic wr_stb, rd_done;

	smi_frame_port u_smi (
		.clk(clk),
		.rst(rst),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe),
		.phy_addr(phy_addr),
		.reg_addr(reg_addr),
		.rd_data(rd_data),
		.wr_data(wr_data),
		.wr_stb(wr_stb),
		.rd_done(rd_done)
	);

	wire logic rd1 = rd_done && reg_is(reg_addr, REG_BASIC_STATUS);
	wire logic rd6 = rd_done && reg_is(reg_addr, REG_AN_EXPANSION);
	wire logic rd29 = rd_done && reg_is(reg_addr, REG_IRQ_FLAGS);
	wire logic wr17 = wr_stb && reg_is(reg_addr, REG_MODE_CTRL);
	wire logic wr29 = wr_stb && reg_is(reg_addr, REG_IRQ_FLAGS);
	wire logic wr30 = wr_stb && reg_is(reg_addr, REG_IRQ_MASK);

	// ****************************************************************
	// Source events
	// ****************************************************************
	// Link is inverted so every source asserts on a rising level
	wire logic [7:1] src = {line_energy_present, an_complete, remote_fault,
		~link_status, lp_acknowledge, parallel_det_fault, page_received};
	logic [7:1] src_prev_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_prev_r <= SRC_PREV_RST;
		end else begin
			src_prev_r <= src;
		end
	end

	wire logic [7:1] rise = src & ~src_prev_r;
	wire logic [7:1] fall = ~src & src_prev_r;
	wire logic link_fall = rise[FLAG_LINK];

	// ****************************************************************
	// Mode select
	// ****************************************************************
	logic alt_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alt_r <= 1'b0;
		end else if (wr17) begin
			alt_r <= wr_data[BIT_ALT_SEL];
		end
	end
	assign alternate_irq_mode_select = alt_r;

	// ****************************************************************
	// Mask register
	// ****************************************************************
	logic [7:1] mask_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_r <= MASK_RST;
		end else if (wr30) begin
			mask_r <= wr_data[7:1];
		end
	end

	// ****************************************************************
	// Release terms
	// ****************************************************************
	wire logic an_rel = rd6 || an_restart || link_fall;
	wire logic [7:1] rd_rel = {2'b00, rd1, rd1, 1'b0, an_rel, an_rel};
	wire logic [7:1] clr_pri = (fall & FALL_REL_MASK) | {7{rd29}} | rd_rel;
	// Clear only if the cause has gone: source low, link back up
	wire logic [7:1] clr_alt = {7{wr29}} & wr_data[7:1] & ~src;
	wire logic [7:1] clr = alt_r ? clr_alt : clr_pri;

	// ****************************************************************
	// Flag register
	// ****************************************************************
	logic [7:1] flags_r;
	logic [7:1] flags_nxt;
	generate
		for (genvar i = 1; i <= 7; i++) begin : g_flag
			// Event in the same cycle as a release keeps the flag
			assign flags_nxt[i] = rise[i] | (flags_r[i] & ~clr[i]);
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_r <= FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ****************************************************************
	// Late energy reassertion
	// ****************************************************************
	late_state_t late_r;
	logic [24:0] late_cnt_r;
	wire logic e_rel_hi = !alt_r && mask_r[FLAG_ENERGY] && flags_r[FLAG_ENERGY]
		&& clr_pri[FLAG_ENERGY] && src[FLAG_ENERGY] && !rise[FLAG_ENERGY];
	wire logic late_on = (late_r == E_PULSE) && mask_r[FLAG_ENERGY];
	wire logic cnt_zero = (late_cnt_r == 25'h0000000);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			late_r <= E_IDLE;
			late_cnt_r <= 25'h0000000;
		end else begin
			case (late_r)
			E_IDLE: begin
				if (e_rel_hi) begin
					late_r <= E_ARMED;
				end
			end
			E_ARMED: begin
				if (!mask_r[FLAG_ENERGY] || alt_r) begin
					late_r <= E_IDLE;
				end else if (fall[FLAG_ENERGY]) begin
					late_r <= E_WAIT;
					late_cnt_r <= 25'(LATE_DELAY_CYC - 1);
				end
			end
			E_WAIT: begin
				late_cnt_r <= late_cnt_r - 25'h0000001;
				if (cnt_zero) begin
					late_r <= E_PULSE;
					late_cnt_r <= 25'(LATE_PULSE_CYC - 1);
				end
			end
			E_PULSE: begin
				late_cnt_r <= late_cnt_r - 25'h0000001;
				if (cnt_zero) begin
					late_r <= E_IDLE;
				end
			end
			default: begin
				late_r <= E_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// Interrupt output
	// ****************************************************************
	wire logic pend_nxt = |(flags_nxt & mask_r);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_out_low <= 1'b1;
		end else begin
			irq_out_low <= ~(pend_nxt | late_on);
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	word_t rd_bsr, rd_lpa, rd_anx, rd_mcs;
	always_comb begin
		rd_bsr = 16'h0000;
		rd_bsr[BIT_ANC] = an_complete;
		rd_bsr[BIT_RFAULT] = remote_fault;
		rd_bsr[BIT_LINK] = link_status;
		rd_lpa = 16'h0000;
		rd_lpa[BIT_ACK] = lp_acknowledge;
		rd_anx = 16'h0000;
		rd_anx[BIT_PDF] = parallel_det_fault;
		rd_anx[BIT_PAGE] = page_received;
		rd_mcs = 16'h0000;
		rd_mcs[BIT_ALT_SEL] = alt_r;
		rd_mcs[BIT_ENERGY] = line_energy_present;
	end

	assign rd_data =
		reg_is(reg_addr, REG_BASIC_STATUS) ? rd_bsr :
		reg_is(reg_addr, REG_LP_ABILITY) ? rd_lpa :
		reg_is(reg_addr, REG_AN_EXPANSION) ? rd_anx :
		reg_is(reg_addr, REG_MODE_CTRL) ? rd_mcs :
		reg_is(reg_addr, REG_IRQ_FLAGS) ? {8'h00, flags_r, 1'b0} :
		reg_is(reg_addr, REG_IRQ_MASK) ? {8'h00, mask_r, 1'b0} :
		16'h0000;

endmodule

/* phy_irq_chk.sv */
// Port-level checker for the management interrupt block.
// Assumes mdc stands still between frames and toggles every 400 ns in them.
`timescale 1ns/100ps
module phy_irq_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire phy_irq_pkg::addr_t phy_addr,
	input wire logic line_energy_present,
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic link_status,
	input wire logic lp_acknowledge,
	input wire logic parallel_det_fault,
	input wire logic page_received,
	input wire logic an_restart,
	input wire logic irq_out_low,
	input wire logic alternate_irq_mode_select
);
	import phy_irq_pkg::*;
	logic [3:0] calm_r;
	logic [3:0] mdc_age_r;
	wire logic [9:0] ins = {mdc, line_energy_present, an_complete, remote_fault, link_status,
		lp_acknowledge, parallel_det_fault, page_received, an_restart, alternate_irq_mode_select};
	// Cycles since anything moved, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			calm_r <= 4'h0;
			mdc_age_r <= 4'h0;
		end else begin
			calm_r <= $changed(ins) ? 4'h0 : calm_r + 4'(calm_r != 4'hF);
			mdc_age_r <= $changed(mdc) ? 4'h0 : mdc_age_r + 4'(mdc_age_r != 4'hF);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_reset_idle: assert property ($fell(rst) |-> irq_out_low && !alternate_irq_mode_select)
		else $error("irq or mode not idle after reset");
	chk_ta_low: assert property ($rose(mdio_oe) |-> !mdio_out)
		else $error("turnaround not driven low");
	chk_oe_span: assert property ($rose(mdio_oe) |-> mdio_oe [*8])
		else $error("drive shorter than one bit");
	chk_bit_stands: assert property (mdio_oe && $changed(mdio_out) |=> $stable(mdio_out) [*7])
		else $error("read bit did not stand");
	chk_oe_in_frame: assert property (mdio_oe |-> mdc_age_r < 4'h8)
		else $error("data driven outside a frame");
	chk_mode_by_frame: assert property ($changed(alternate_irq_mode_select) |-> mdc_age_r < 4'h8)
		else $error("mode moved without a write");
	chk_alt_hold: assert property (alternate_irq_mode_select && calm_r > 4'h7 |-> $stable(irq_out_low))
		else $error("irq moved with no cause");
	chk_irq_by_cause: assert property (alternate_irq_mode_select && $changed(irq_out_low) |-> calm_r < 4'h5)
		else $error("irq late after its cause");
endmodule

bind phy_mgmt_interrupt_logic phy_irq_chk chk_u (
	.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
	.mdio_oe(mdio_oe), .phy_addr(phy_addr), .line_energy_present(line_energy_present),
	.an_complete(an_complete), .remote_fault(remote_fault), .link_status(link_status),
	.lp_acknowledge(lp_acknowledge), .parallel_det_fault(parallel_det_fault),
	.page_received(page_received), .an_restart(an_restart), .irq_out_low(irq_out_low),
	.alternate_irq_mode_select(alternate_irq_mode_select));

/* smi_master_model.sv */
// Station management controller model: sends read and write frames.
// Assumes a pull-up on the data line; mdc stands low between frames.
`timescale 1ns/100ps
module smi_master_model (
	output logic mdc,
	output logic mdio_drv,
	input wire logic mdio,
	input wire phy_irq_pkg::addr_t pa
);
	import phy_irq_pkg::*;
	initial begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
	end
	task automatic xfer(input logic [1:0] op, input addr_t ra, input word_t wd, output word_t rd);
		logic [63:0] f;
		f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			// Released to the pull-up while the device answers
			mdio_drv = (op == OP_READ && i < 18) ? 1'b1 : f[i];
			#400 mdc = 1'b1;
			if (i < 16)
				rd[i] = mdio;
			#400 mdc = 1'b0;
		end
		mdio_drv = 1'b1;
	endtask
endmodule

/* phy_mgmt_interrupt_logic_tb_top.sv */
// Testbench for the management interrupt block.
// Assumes shortened late-energy counts and an 800 ns management clock.
`timescale 1ns/100ps
module phy_mgmt_interrupt_logic_tb_top;
	import phy_irq_pkg::*;
	localparam int DLY = 50;
	localparam int PLS = 20;
	logic clk;
	logic rst;
	logic an_restart;
	logic [7:1] src;
	addr_t pa;
	addr_t m_pa;
	logic mdc;
	logic mdio_drv;
	logic mdio_out;
	logic mdio_oe;
	logic irq_out_low;
	logic alt_sel;
	wire logic mdio_w = mdio_oe ? mdio_out : mdio_drv;
	int error_cnt = 0;
	int checks = 0;
	word_t rdat;

	phy_mgmt_interrupt_logic #(.LATE_DELAY_CYC(DLY), .LATE_PULSE_CYC(PLS)) dut_u (
		.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .phy_addr(pa), .line_energy_present(src[7]), .an_complete(src[6]),
		.remote_fault(src[5]), .link_status(!src[4]), .lp_acknowledge(src[3]),
		.parallel_det_fault(src[2]), .page_received(src[1]), .an_restart(an_restart),
		.irq_out_low(irq_out_low), .alternate_irq_mode_select(alt_sel));
	smi_master_model mst_u (.mdc(mdc), .mdio_drv(mdio_drv), .mdio(mdio_w), .pa(m_pa));

	task automatic chk(input string n, input word_t got, input word_t exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic settle();
		repeat (10) @(negedge clk);
	endtask
	task automatic wr(input addr_t a, input word_t d);
		word_t x;
		mst_u.xfer(OP_WRITE, a, d, x);
		settle();
	endtask
	task automatic rd(input addr_t a);
		mst_u.xfer(OP_READ, a, 16'h0000, rdat);
		settle();
	endtask
	task automatic put(input int k, input logic v);
		src[k] = v;
		settle();
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic t_reset();
		chk("irq", irq_out_low, 16'h0001);
		rd(REG_IRQ_FLAGS);
		chk("flags", rdat, 16'h0080);
		rd(REG_MODE_CTRL);
		chk("mode reg", rdat, 16'h0002);
		rd(5'h0A);
		chk("unmapped", rdat, 16'h0000);
		m_pa = 5'h04;
		rd(REG_IRQ_MASK);
		chk("other addr", rdat, 16'hFFFF);
		m_pa = pa;
		$display("done reset");
	endtask
	task automatic t_primary();
		src = 7'h00;
		settle();
		for (int k = 1; k < 7; k++) begin
			wr(REG_IRQ_MASK, word_t'(1) << k);
			put(k, 1'b1);
			chk("assert", irq_out_low, 16'h0000);
			put(k, 1'b0);
			chk("fall", irq_out_low, {15'h0000, k != 4});
			if (k != 4)
				put(k, 1'b1);
			if (k == 4) begin
				wr(REG_IRQ_FLAGS, 16'h0010);
				chk("w29 ignored", irq_out_low, 16'h0000);
			end
			if (k == 4 || k == 5) begin
				rd(REG_BASIC_STATUS);
				chk("status", rdat, (k == 5) ? 16'h0014 : 16'h0004);
			end else if (k == 1) begin
				rd(REG_AN_EXPANSION);
				chk("expansion", rdat, 16'h0002);
			end else if (k == 2) begin
				an_restart = 1'b1;
				@(negedge clk);
				an_restart = 1'b0;
				settle();
			end else begin
				if (k == 3) begin
					rd(REG_LP_ABILITY);
					chk("partner", rdat, 16'h4000);
					chk("rd5 keeps", irq_out_low, 16'h0000);
				end
				rd(REG_IRQ_FLAGS);
				chk("flag", rdat, word_t'(1) << k);
			end
			chk("release", irq_out_low, 16'h0001);
			src[k] = 1'b0;
		end
		$display("done primary");
	endtask
	task automatic t_late();
		int lows;
		int first;
		wr(REG_IRQ_MASK, 16'h0080);
		put(7, 1'b1);
		chk("energy", irq_out_low, 16'h0000);
		put(7, 1'b0);
		chk("energy fall", irq_out_low, 16'h0001);
		put(7, 1'b1);
		chk("energy again", irq_out_low, 16'h0000);
		rd(REG_IRQ_FLAGS);
		chk("read release", irq_out_low, 16'h0001);
		src[7] = 1'b0;
		lows = 0;
		first = 0;
		for (int c = 1; c < 3 * DLY; c++) begin
			@(negedge clk);
			if (!irq_out_low && first == 0)
				first = c;
			lows += !irq_out_low;
		end
		chk("late start", {15'h0000, first >= DLY && first <= DLY + 3}, 16'h0001);
		chk("late length", word_t'(lows), word_t'(PLS));
		wr(REG_IRQ_MASK, 16'h0000);
		$display("done late");
	endtask
	task automatic t_alt();
		wr(REG_MODE_CTRL, 16'h0040);
		chk("mode", alt_sel, 16'h0001);
		wr(REG_IRQ_MASK, 16'h00FE);
		rd(REG_IRQ_MASK);
		chk("mask", rdat, 16'h00FE);
		put(6, 1'b1);
		chk("alt assert", irq_out_low, 16'h0000);
		wr(REG_IRQ_FLAGS, 16'h0040);
		chk("cause on", irq_out_low, 16'h0000);
		put(6, 1'b0);
		rd(REG_IRQ_FLAGS);
		chk("flag kept", rdat, 16'h0040);
		wr(REG_IRQ_FLAGS, 16'h0040);
		chk("cleared", irq_out_low, 16'h0001);
		put(4, 1'b1);
		wr(REG_IRQ_FLAGS, 16'h0010);
		chk("link down", irq_out_low, 16'h0000);
		put(4, 1'b0);
		wr(REG_IRQ_FLAGS, 16'h0010);
		chk("link up", irq_out_low, 16'h0001);
		put(3, 1'b1);
		wr(REG_IRQ_MASK, 16'h0000);
		chk("unmasked", irq_out_low, 16'h0001);
		put(3, 1'b0);
		wr(REG_MODE_CTRL, 16'h0000);
		chk("primary", alt_sel, 16'h0000);
		$display("done alt");
	endtask
	task automatic t_rerun();
		wr(REG_MODE_CTRL, 16'h0040);
		chk("alt again", alt_sel, 16'h0001);
		src[7] = 1'b1;
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		settle();
		chk("rerun mode", alt_sel, 16'h0000);
		chk("rerun irq", irq_out_low, 16'h0001);
		rd(REG_IRQ_FLAGS);
		chk("rerun flags", rdat, 16'h0080);
		$display("done rerun");
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		an_restart = 1'b0;
		src = 7'h40;
		pa = 5'h03;
		m_pa = 5'h03;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		settle();
		t_reset();
		t_primary();
		t_late();
		t_alt();
		t_rerun();
		close_out();
	end
endmodule
